/* File: verilog/tcc_defs.svh */
// register offsets, field positions, reset values of the capture/compare timer
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH
`define TCC_OFS_CTRL 8'h00
`define TCC_OFS_CNTH 8'h04
`define TCC_OFS_CNTL 8'h08
`define TCC_OFS_RLDH 8'h0C
`define TCC_OFS_RLDL 8'h10
`define TCC_OFS_CAPH 8'h14
`define TCC_OFS_CAPL 8'h18
`define TCC_OFS_STAT 8'h1C
`define TCC_CTRL_EN 0
`define TCC_CTRL_POL 1
`define TCC_CTRL_MODE_LO 2
`define TCC_CTRL_IES_LO 4
`define TCC_CTRL_PRE_LO 8
`define TCC_CTRL_AF 12
`define TCC_CTRL_RST 32'h0000_0000
`define TCC_CNT_RST 16'h0001
`define TCC_RLD_RST 16'hFFFF
`endif

/* File: verilog/tcc_pkg.sv */
// types of the capture/compare timer
package tcc_pkg;
  typedef enum logic [1:0] {
    TCC_IES_BOTH = 2'b00,
    TCC_IES_CAP = 2'b01,
    TCC_IES_RLD = 2'b10,
    TCC_IES_BOTH2 = 2'b11
  } tcc_ies_e;
  typedef enum logic [1:0] {
    TCC_MODE_CAPCMP = 2'b00,
    TCC_MODE_DUALPWM = 2'b01,
    TCC_MODE_OTHER = 2'b10,
    TCC_MODE_OTHER2 = 2'b11
  } tcc_mode_e;
  typedef enum logic [1:0] {
    TCC_ST_IDLE = 2'b00,
    TCC_ST_WAIT = 2'b01,
    TCC_ST_RUN = 2'b10
  } tcc_st_e;
  // field order gives the control word bit layout, enable at bit 0
  typedef struct packed {
    logic altFunc;
    logic [3:0] prescale;
    logic [1:0] spare;
    tcc_ies_e intSel;
    tcc_mode_e mode;
    logic capRising;
    logic enable;
  } tcc_ctrl_s;
  typedef struct packed {
    logic capture;
    logic reload;
  } tcc_evt_s;
endpackage

/* File: verilog/tcc_timer.sv */
// 16-bit capture/compare timer with axi4-lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defs.svh"
module tcc_timer #(
  parameter int CNT_W = 16
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timerPinIn,
  output logic timerPinOut,
  output logic timerPinOe,
  output logic timerIrq
);
  import tcc_pkg::*;

  // ********************************
  // register state
  // ********************************
  tcc_ctrl_s ctrl_r, ctrl_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt, start_r, start_nxt;
  logic [CNT_W-1:0] rld_r, rld_nxt, cap_r, cap_nxt;
  logic [7:0] hold_r, hold_nxt;
  logic [15:0] pre_r, pre_nxt;
  tcc_st_e st_r, st_nxt;
  logic pinSync_r, pinDly_r, pinDly_nxt, pinPrev_r, tout_r, tout_nxt;
  logic [1:0] flags_r, flags_nxt;
  logic awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt, bv_r, bv_nxt;
  logic rv_r, rv_nxt;
  logic [7:0] awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
  logic doWr, doRd, edgeSeen, tick, atCmp, inputMode;
  tcc_evt_s evt;
  logic [31:0] wMask, rdVal;
  logic [7:0] ra;

  // ********************************
  // axi handshakes
  // ********************************
  assign s_axi_awready = !awHeld_r && !bv_r;
  assign s_axi_wready = !wHeld_r && !bv_r;
  assign s_axi_arready = !rv_r;
  assign s_axi_bvalid = bv_r;
  assign s_axi_bresp = 2'b00;
  assign s_axi_rvalid = rv_r;
  assign s_axi_rdata = rd_r;
  assign s_axi_rresp = 2'b00;
  assign doWr = (awHeld_r || s_axi_awvalid) && (wHeld_r || s_axi_wvalid)
    && !bv_r;
  assign doRd = s_axi_arvalid && !rv_r;
  assign ra = s_axi_araddr;

  // ********************************
  // pin and timebase
  // ********************************
  // mode chooses the pin role
  assign inputMode = ctrl_r.mode != TCC_MODE_DUALPWM;
  // sync flop feeds only the delay flop
  assign edgeSeen = inputMode && ctrl_r.altFunc &&
    (ctrl_r.capRising ? (pinDly_r && !pinPrev_r) :
    (!pinDly_r && pinPrev_r));
  assign tick = pre_r >= 16'(ctrl_r.prescale == 4'h0 ? 1 :
    (1 << ctrl_r.prescale)) - 16'h0001;
  assign atCmp = cnt_r == rld_r;
  assign timerPinOut = tout_r;
  assign timerPinOe = ctrl_r.altFunc && !inputMode;
  // limit interrupt to chosen event kinds
  assign timerIrq = (flags_r[1] && ctrl_r.intSel != TCC_IES_RLD) ||
    (flags_r[0] && ctrl_r.intSel != TCC_IES_CAP);

  always_comb
  begin
    for (int i = 0; i < 32; i++)
      wMask[i] = s_axi_wstrb[i/8];
    case (ra)
      `TCC_OFS_CTRL: rdVal = 32'(ctrl_r) ;
      `TCC_OFS_CNTH: rdVal = {24'h00_0000, cnt_r[15:8]};
      // latched copy whenever enable is set
      `TCC_OFS_CNTL: rdVal = {24'h00_0000,
        ctrl_r.enable ? hold_r : cnt_r[7:0]};
      `TCC_OFS_RLDH: rdVal = {24'h00_0000, rld_r[15:8]};
      `TCC_OFS_RLDL: rdVal = {24'h00_0000, rld_r[7:0]};
      `TCC_OFS_CAPH: rdVal = {24'h00_0000, cap_r[15:8]};
      `TCC_OFS_CAPL: rdVal = {24'h00_0000, cap_r[7:0]};
      `TCC_OFS_STAT: rdVal = {28'h000_0000, st_r, flags_r};
      default: rdVal = 32'h0000_0000;
    endcase
  end

  // ********************************
  // next state
  // ********************************
  always_comb
  begin
    logic [7:0] wa;
    logic [31:0] wd;
    wa = awHeld_r ? awa_r : s_axi_awaddr;
    wd = wHeld_r ? wd_r : (s_axi_wdata & wMask);
    ctrl_nxt = ctrl_r;
    cnt_nxt = cnt_r;
    start_nxt = start_r;
    rld_nxt = rld_r;
    cap_nxt = cap_r;
    hold_nxt = hold_r;
    pre_nxt = pre_r;
    st_nxt = st_r;
    tout_nxt = tout_r;
    flags_nxt = flags_r;
    pinDly_nxt = pinSync_r;
    evt = '0;
    awHeld_nxt = awHeld_r;
    wHeld_nxt = wHeld_r;
    awa_nxt = awa_r;
    wd_nxt = wd_r;
    bv_nxt = bv_r && !s_axi_bready;
    rv_nxt = rv_r && !s_axi_rready;
    rd_nxt = rd_r;
    if (s_axi_awvalid && s_axi_awready && !doWr)
    begin
      awHeld_nxt = 1'b1;
      awa_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready && !doWr)
    begin
      wHeld_nxt = 1'b1;
      wd_nxt = s_axi_wdata & wMask;
    end
    if (doRd)
    begin
      rv_nxt = 1'b1;
      rd_nxt = rdVal;
      if (ra == `TCC_OFS_CNTH && ctrl_r.enable)
        hold_nxt = cnt_r[7:0];
    end
    // timer engine
    if (!ctrl_r.enable)
    begin
      st_nxt = TCC_ST_IDLE;
      pre_nxt = 16'h0000;
    end
    else if (st_r != TCC_ST_RUN)
    begin
      st_nxt = TCC_ST_WAIT;
      if (edgeSeen)
        st_nxt = TCC_ST_RUN;
    end
    else
    begin
      pre_nxt = tick ? 16'h0000 : pre_r + 16'h0001;
      if (tick)
      begin
        if (atCmp)
        begin
          cnt_nxt = start_r;
          tout_nxt = !tout_r;
          evt.reload = 1'b1;
        end
        else
          cnt_nxt = cnt_r + 16'h0001;
      end
      if (edgeSeen)
      begin
        cap_nxt = cnt_r;
        evt.capture = 1'b1;
      end
    end
    if (doWr)
    begin
      bv_nxt = 1'b1;
      awHeld_nxt = 1'b0;
      wHeld_nxt = 1'b0;
      case (wa)
        `TCC_OFS_CTRL:
        begin
          ctrl_nxt = tcc_ctrl_s'(wd[12:0]);
          // unused bits always read back as zero
          ctrl_nxt.spare = 2'b00;
        end
        `TCC_OFS_CNTH:
        begin
          cnt_nxt[15:8] = wd[7:0];
          start_nxt[15:8] = wd[7:0];
        end
        `TCC_OFS_CNTL:
        begin
          cnt_nxt[7:0] = wd[7:0];
          start_nxt[7:0] = wd[7:0];
        end
        `TCC_OFS_RLDH: rld_nxt[15:8] = wd[7:0];
        `TCC_OFS_RLDL: rld_nxt[7:0] = wd[7:0];
        // write one to clear, event set wins
        `TCC_OFS_STAT: flags_nxt = flags_r & ~wd[1:0];
        default: ;
      endcase
    end
    flags_nxt = flags_nxt | {evt.capture, evt.reload};
  end

  // ********************************
  // registers
  // ********************************
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_r <= tcc_ctrl_s'(13'(`TCC_CTRL_RST));
      cnt_r <= `TCC_CNT_RST;
      start_r <= `TCC_CNT_RST;
      rld_r <= `TCC_RLD_RST;
      cap_r <= 16'h0000;
      hold_r <= 8'h00;
      pre_r <= 16'h0000;
      st_r <= TCC_ST_IDLE;
      pinSync_r <= 1'b0;
      pinDly_r <= 1'b0;
      pinPrev_r <= 1'b0;
      tout_r <= 1'b0;
      flags_r <= 2'b00;
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awa_r <= 8'h00;
      wd_r <= 32'h0000_0000;
      bv_r <= 1'b0;
      rv_r <= 1'b0;
      rd_r <= 32'h0000_0000;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      cnt_r <= cnt_nxt;
      start_r <= start_nxt;
      rld_r <= rld_nxt;
      cap_r <= cap_nxt;
      hold_r <= hold_nxt;
      pre_r <= pre_nxt;
      st_r <= st_nxt;
      pinSync_r <= timerPinIn;
      pinDly_r <= pinDly_nxt;
      pinPrev_r <= pinDly_r;
      tout_r <= tout_nxt;
      flags_r <= flags_nxt;
      awHeld_r <= awHeld_nxt;
      wHeld_r <= wHeld_nxt;
      awa_r <= awa_nxt;
      wd_r <= wd_nxt;
      bv_r <= bv_nxt;
      rv_r <= rv_nxt;
      rd_r <= rd_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: bench/tcc_timer_assertions.sv */
// checker of the timer's register bus handshake
`timescale 1ns/1ps
`default_nettype none
module tcc_chk (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // *******
  // bus rules
  // *******
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid) else $error("no bvalid");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  a_wr_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid stuck");
  a_wr_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("awready during response");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  a_rd_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid stuck");
  a_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready during response");
  a_wr_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
    else $error("bad bresp");
endmodule
bind tcc_timer tcc_chk chk_u (.*);
`default_nettype wire

/* File: bench/tcc_pin_drv.sv */
// far side: external source of edges on the timer input
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_drv (
  input wire logic clk_sys,
  input wire logic pulseReq,
  output logic timerPinIn
);
  int hold = 0;
  // high for four clocks so the double flop always sees it
  always @(posedge clk_sys)
  begin
    if (pulseReq)
      hold <= 3;
    else if (hold > 0)
      hold <= hold - 1;
    timerPinIn <= pulseReq || hold > 0;
  end
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// self-checking bench of the capture/compare timer
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, timerPinIn;
  logic timerPinOut, timerPinOe, timerIrq, pulseReq, lastOut;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q, c1;
  logic [15:0] cap, lastCap;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int errors, check_count, seed, cyc, togs, g, i;
  int edgeQ[$];
  tcc_timer dut_u (.*);
  tcc_pin_drv pin_u (.clk_sys, .pulseReq, .timerPinIn);
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    lastOut <= timerPinOut;
    if (timerPinOut !== lastOut)
      togs <= togs + 1;
  end
  // *******
  // tasks
  // *******
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hr;
    int n;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    hr = 1'b0;
    for (n = 0; !hr; n++)
    begin
      #1;
      ha = s_axi_awready && s_axi_awvalid || s_axi_arready && s_axi_arvalid;
      hw = s_axi_wready && s_axi_wvalid;
      hr = w ? s_axi_bvalid : s_axi_rvalid;
      q = s_axi_rdata;
      @(posedge clk_sys);
      if (ha)
        {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
      if (hw)
        s_axi_wvalid <= 1'b0;
      if (hr)
        {s_axi_bready, s_axi_rready} <= 2'h0;
      if (n > 40)
        errors++;
      if (n > 40)
        tally_and_finish();
    end
  endtask
  task automatic pulse;
    @(posedge clk_sys);
    pulseReq <= 1'b1;
    edgeQ.push_back(cyc);
    @(posedge clk_sys);
    pulseReq <= 1'b0;
  endtask
  // *******
  // scenarios
  // *******
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, pulseReq} = 4'h0;
    {s_axi_arvalid, s_axi_rready, lastOut} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    seed = 49002;
    errors = 0;
    check_count = 0;
    cyc = 0;
    togs = 0;
    sys_rst = 1'b1;
    tick(2);
    sys_rst <= 1'b0;
    bus(0, 8'h00, 0); chk(q, 32'h0000_0000);
    bus(0, 8'h08, 0); chk(q, 32'h0000_0001);
    bus(0, 8'h10, 0); chk(q, 32'h0000_00FF);
    bus(0, 8'h20, 0); chk(q, 32'h0000_0000);
    bus(1, 8'h00, 32'h0000_1103);
    bus(0, 8'h1C, 0); chk(q, 32'h0000_0004);
    pulse();
    tick(8);
    chk(timerIrq, 1'b0);
    bus(0, 8'h1C, 0); chk(q, 32'h0000_0008);
    for (i = 0; i < 4; i++)
    begin
      g = 2 * (($random(seed) & 7) + 24);
      // pulse itself waits one more edge, so the gap is exactly g
      while (cyc < edgeQ[$] + g - 1) @(posedge clk_sys);
      pulse();
      tick(8);
      chk(timerIrq, 1'b1);
      bus(1, 8'h1C, 32'h0000_0002);
      bus(0, 8'h14, 0); cap[15:8] = q[7:0];
      bus(0, 8'h18, 0); cap[7:0] = q[7:0];
      // start edge holds no capture, so the first gap is skipped
      if (i > 0) chk(cap - lastCap, (edgeQ[$] - edgeQ[$-1]) / 2);
      lastCap = cap;
      bus(0, 8'h04, 0);
      bus(0, 8'h08, 0); c1 = q;
      bus(0, 8'h08, 0); chk(q, c1);
    end
    bus(1, 8'h00, 32'h0000_1102);
    bus(1, 8'h04, 0);
    bus(1, 8'h08, 32'h0000_0001);
    bus(1, 8'h0C, 0);
    bus(1, 8'h10, 32'h0000_0006);
    bus(1, 8'h1C, 32'h0000_0003);
    bus(1, 8'h00, 32'h0000_1113);
    pulse();
    g = togs;
    tick(60);
    bus(0, 8'h1C, 0); chk(q, 32'h0000_0009);
    chk(timerIrq, 1'b0);
    chk(togs - g > 2, 1'b1);
    pulse();
    tick(8);
    chk(timerIrq, 1'b1);
    bus(1, 8'h00, 32'h0000_1004);
    tick(2);
    chk(timerPinOe, 1'b1);
    bus(1, 8'h00, 32'h0000_0000);
    tick(2);
    chk(timerPinOe, 1'b0);
    bus(1, 8'h08, 32'h0000_005A);
    bus(0, 8'h08, 0); chk(q[7:0], 8'h5A);
    tally_and_finish();
  end
endmodule
`default_nettype wire
